// ### hw/umr_rx.sv
// Serial receiver with start validation, majority voting and multi-processor filter.
// Contract
// - Falling edge on idle line starts detection.
// - Start checked at samples 8-10 or 4-6.
// - Two high checks reject start as noise.
// - Realign bit phase on every start bit.
// - Per-bit counter of 16 or 8 states.
// - Each bit takes majority of centre samples.
// - Stop after first stop bit; ignore others.
// - Low first stop bit sets frame error.
// - Next start accepted right after stop vote.
// - Remote bit rate within receiver tolerance.
// - Filter mode drops non-address frames.
// - Type bit: stop bit, or ninth bit.
// - Type one is address, zero is data.
// - Filter mode never affects the transmitter.
// - Master uses 9-bit frames, ninth marks address.
// - Address frames stored and flagged as normal.
// - Slave software clears and resets filter mode.
// - 5-8 bit protocol needs two stop bits.
// - No bitwise read-modify-write of filter bit.
// - Sixteen samples per bit, eight in double.
// - Error flags travel with their buffered frame.
`timescale 1ns/1ps
module umr_rx (
  input  wire logic        clk,             // System clock.
  input  wire logic        reset,           // Synchronous reset, active high.
  umr_line_if.rx_end       ser,             // Serial line from the remote end.
  input  wire logic [3:0]  avs_address,     // Byte address.
  input  wire logic        avs_read,        // Read request.
  input  wire logic        avs_write,       // Write request.
  input  wire logic [31:0] avs_writedata,   // Write data.
  output logic      [31:0] avs_readdata,    // Read data.
  output logic             avs_waitrequest  // Low for one cycle to end a request.
);
  typedef struct packed {
    logic                                sync1;
    logic                                sync2;
    logic                                prev;
    umr_pkg::umr_rx_state_t              st;
    logic [4:0]                          cnt;
    logic [2:0]                          smp;
    logic [3:0]                          bidx;
    logic [8:0]                          data;
    logic                                parity_error_flag;
    logic [7:0]                          ctrl;
    logic [15:0]                         div;
    logic [15:0]                         tcnt;
    logic [1:0][umr_pkg::ENT_W-1:0]      buf_q;
    logic [1:0]                          fcnt;
    logic                                pend_dor;
    logic                                waitreq;
    logic [31:0]                         rdata;
  } umr_rx_regs_t;

  umr_rx_regs_t r;
  umr_rx_regs_t next_r;

  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic is_ofs(input logic [3:0] a, input logic [3:0] ofs);
    is_ofs = {a[3:2], 2'h0} == ofs;
  endfunction

  logic                       tick;
  logic                       dspd;
  logic [4:0]                 spb_n;
  logic [4:0]                 first;
  logic [4:0]                 cnt_inc;
  logic [3:0]                 nbits;
  logic [3:0]                 last_idx;
  logic [2:0]                 win;
  logic                       bitv;
  logic                       ftype;
  logic [umr_pkg::ENT_W-1:0]  head;
  logic [umr_pkg::ENT_W-1:0]  ent;

  always_comb begin
    next_r   = r;
    tick     = r.tcnt == 16'h0000;
    dspd     = r.ctrl[umr_pkg::CTL_DSPD];
    spb_n    = umr_pkg::spb(dspd);
    first    = dspd ? umr_pkg::FIRST_DBL : umr_pkg::FIRST_NORM;
    cnt_inc  = (r.cnt == spb_n) ? 5'h01 : r.cnt + 5'h01;
    nbits    = umr_pkg::char_bits(r.ctrl[umr_pkg::CTL_CSZ_LO +: 3]);
    last_idx = nbits + {3'h0, r.ctrl[umr_pkg::CTL_PEN]};
    win      = {r.smp[1:0], r.sync2};
    bitv     = vote3(win);
    ftype    = 1'b0;
    head     = r.buf_q[0];
    ent      = '0;

    next_r.sync1 = ser.line;
    next_r.sync2 = r.sync1;
    next_r.tcnt  = tick ? r.div : r.tcnt - 16'h0001;

    // Bus slave: request accepted on the first edge, completed one cycle later.
    next_r.waitreq = 1'b1;
    if ((avs_read || avs_write) && r.waitreq) begin
      next_r.waitreq = 1'b0;
      next_r.rdata   = 32'h0000_0000;
      if (avs_read) begin
        if (is_ofs(avs_address, umr_pkg::OFS_CTRL)) begin
          next_r.rdata[7:0] = r.ctrl;
        end else if (is_ofs(avs_address, umr_pkg::OFS_STATUS)) begin
          next_r.rdata[umr_pkg::ST_RXC]   = r.fcnt != 2'h0;
          next_r.rdata[umr_pkg::ST_FE]    = (r.fcnt != 2'h0) & head[umr_pkg::ENT_FE];
          next_r.rdata[umr_pkg::ST_DOR]   = (r.fcnt != 2'h0) & head[umr_pkg::ENT_DOR];
          next_r.rdata[umr_pkg::ST_UPE]   = (r.fcnt != 2'h0) & head[umr_pkg::ENT_UPE];
          next_r.rdata[umr_pkg::ST_NINTH] = (r.fcnt != 2'h0) & head[8];
        end else if (is_ofs(avs_address, umr_pkg::OFS_DATA)) begin
          if (r.fcnt != 2'h0) begin
            next_r.rdata[8:0] = head[8:0];
            next_r.buf_q[0] = r.buf_q[1];
            next_r.buf_q[1] = '0;
            next_r.fcnt     = r.fcnt - 2'h1;
          end
        end else if (is_ofs(avs_address, umr_pkg::OFS_DIV)) begin
          next_r.rdata[15:0] = r.div;
        end
      end
    end
    if (avs_write && !r.waitreq) begin
      if (is_ofs(avs_address, umr_pkg::OFS_CTRL)) begin
        next_r.ctrl = avs_writedata[7:0];
      end else if (is_ofs(avs_address, umr_pkg::OFS_DIV)) begin
        next_r.div = avs_writedata[15:0];
      end
    end

    if (!r.ctrl[umr_pkg::CTL_RXEN]) begin
      // A disabled receiver drops any frame in flight and empties the buffer.
      next_r.st       = umr_pkg::RX_HUNT;
      next_r.prev     = 1'b0;
      next_r.fcnt     = 2'h0;
      next_r.buf_q    = '0;
      next_r.pend_dor = 1'b0;
    end else if (tick) begin
      unique case (r.st)
        umr_pkg::RX_HUNT: begin
          next_r.prev = r.sync2;
          if (r.prev && !r.sync2) begin
            next_r.st  = umr_pkg::RX_START;
            // This tick took sample one, so the next tick is numbered two.
            next_r.cnt = 5'h02;
            next_r.smp = 3'h0;
          end
        end
        umr_pkg::RX_START: begin
          next_r.cnt = cnt_inc;
          if (r.cnt >= first && r.cnt <= first + 5'h02) begin
            next_r.smp = win;
          end
          if (r.cnt == first + 5'h02) begin
            if (bitv) begin
              next_r.st   = umr_pkg::RX_HUNT;
              next_r.prev = r.sync2;
            end else begin
              next_r.st   = umr_pkg::RX_BITS;
              next_r.bidx = 4'h0;
              next_r.data = 9'h000;
              next_r.parity_error_flag  = 1'b0;
            end
          end
        end
        umr_pkg::RX_BITS: begin
          next_r.cnt = cnt_inc;
          if (r.cnt >= first && r.cnt <= first + 5'h02) begin
            next_r.smp = win;
          end
          if (r.cnt == first + 5'h02) begin
            next_r.bidx = r.bidx + 4'h1;
            if (r.bidx < nbits) begin
              next_r.data[r.bidx] = bitv;
            end else if (r.bidx < last_idx) begin
              next_r.parity_error_flag = bitv != (^r.data ^ r.ctrl[umr_pkg::CTL_PODD]);
            end else begin
              ftype = (nbits == 4'h9) ? r.data[8] : bitv;
              ent = {r.pend_dor, r.parity_error_flag, ~bitv, r.data};
              if (!(r.ctrl[umr_pkg::CTL_FILT] && !ftype)) begin
                if (next_r.fcnt < umr_pkg::RXBUF_DEPTH) begin
                  next_r.buf_q[next_r.fcnt[0]] = ent;
                  next_r.fcnt     = next_r.fcnt + 2'h1;
                  next_r.pend_dor = 1'b0;
                end else begin
                  next_r.pend_dor = 1'b1;
                end
              end
              next_r.st   = umr_pkg::RX_HUNT;
              next_r.prev = bitv;
            end
          end
        end
        default: begin
          next_r.st = umr_pkg::RX_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r          <= '0;
      r.sync1    <= 1'b1;
      r.sync2    <= 1'b1;
      r.st       <= umr_pkg::RX_HUNT;
      r.ctrl     <= umr_pkg::CTRL_RST[7:0];
      r.div      <= umr_pkg::DIV_RST;
      r.waitreq  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.waitreq;
endmodule

// ### hw/umr_pkg.sv
// Shared constants, types and helpers for the serial receiver and its remote transmitter.
package umr_pkg;
  // Register byte offsets on the Avalon-MM slave of each end.
  localparam logic [3:0]  OFS_CTRL     = 4'h0;
  localparam logic [3:0]  OFS_STATUS   = 4'h4;
  localparam logic [3:0]  OFS_DATA     = 4'h8;
  localparam logic [3:0]  OFS_DIV      = 4'hc;
  // Control register fields.
  localparam int          CTL_FILT     = 0;
  localparam int          CTL_DSPD     = 1;
  localparam int          CTL_RXEN     = 2;
  localparam int          CTL_CSZ_LO   = 3;
  localparam int          CTL_PEN      = 6;
  localparam int          CTL_PODD     = 7;
  localparam int          CTL_TWO_STOP = 8;
  localparam int          CTL_NINTH    = 9;
  localparam logic [9:0]  CTRL_RST     = 10'h018;
  localparam logic [15:0] DIV_RST      = 16'h0003;
  // Receiver status fields.
  localparam int          ST_RXC       = 0;
  localparam int          ST_FE        = 1;
  localparam int          ST_DOR       = 2;
  localparam int          ST_UPE       = 3;
  localparam int          ST_NINTH     = 4;
  // Transmitter status fields.
  localparam int          ST_TXC       = 0;
  localparam int          ST_BUSY      = 1;
  // Receive buffer entry layout: nine data bits plus three error flags.
  localparam int          ENT_FE       = 9;
  localparam int          ENT_UPE      = 10;
  localparam int          ENT_DOR      = 11;
  localparam int          ENT_W        = 12;
  localparam logic [1:0]  RXBUF_DEPTH  = 2'h2;
  // Oversampling: samples per bit and first centre sample.
  localparam logic [4:0]  SPB_NORM     = 5'h10;
  localparam logic [4:0]  SPB_DBL      = 5'h08;
  localparam logic [4:0]  FIRST_NORM   = 5'h08;
  localparam logic [4:0]  FIRST_DBL    = 5'h04;
  localparam logic [2:0]  CSZ_NINE     = 3'h7;

  typedef enum logic [2:0] {
    RX_HUNT  = 3'b001,
    RX_START = 3'b010,
    RX_BITS  = 3'b100
  } umr_rx_state_t;

  // Data bits per character for a size code.
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0:    char_bits = 4'h5;
      3'h1:    char_bits = 4'h6;
      3'h2:    char_bits = 4'h7;
      CSZ_NINE: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  function automatic logic [4:0] spb(input logic dspd);
    spb = dspd ? SPB_DBL : SPB_NORM;
  endfunction
endpackage

// ### hw/umr_line_if.sv
// Shared serial line joining the remote transmitter to the receiver.
`timescale 1ns/1ps
interface umr_line_if;
  logic line;
  modport tx_end (output line);
  modport rx_end (input line);
endinterface

// ### hw/umr_tx.sv
// Remote transmitter driving the shared serial line.
`timescale 1ns/1ps
module umr_tx (
  input  wire logic        clk,             // System clock.
  input  wire logic        reset,           // Synchronous reset, active high.
  umr_line_if.tx_end       ser,             // Serial line towards the receiver.
  input  wire logic [3:0]  avs_address,     // Byte address.
  input  wire logic        avs_read,        // Read request.
  input  wire logic        avs_write,       // Write request.
  input  wire logic [31:0] avs_writedata,   // Write data.
  output logic      [31:0] avs_readdata,    // Read data.
  output logic             avs_waitrequest  // Low for one cycle to end a request.
);
  typedef struct packed {
    logic [9:0]  ctrl;
    logic [15:0] div;
    logic [15:0] tcnt;
    logic        busy;
    logic [4:0]  cnt;
    logic [3:0]  bidx;
    logic [3:0]  last;
    logic [12:0] frame;
    logic        txd;
    logic        tx_complete_flag;
    logic        waitreq;
    logic [31:0] rdata;
  } umr_tx_regs_t;

  umr_tx_regs_t r;
  umr_tx_regs_t next_r;

  // Start bit, data bits, optional parity, then ones for the stop bits.
  function automatic logic [12:0] build(input logic [8:0] d, input logic [3:0] n, input logic pen,
                                        input logic podd);
    logic [12:0] f;
    logic        p;
    f = 13'h1ffe;
    p = podd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        f[i + 1] = d[i];
        p        = p ^ d[i];
      end
    end
    if (pen) begin
      f[n + 4'h1] = p;
    end
    return f;
  endfunction

  logic       tick;
  logic       data_wr;
  logic [3:0] nbits;
  logic [8:0] dword;

  always_comb begin
    next_r      = r;
    tick        = r.tcnt == 16'h0000;
    next_r.tcnt = tick ? r.div : r.tcnt - 16'h0001;
    nbits       = umr_pkg::char_bits(r.ctrl[umr_pkg::CTL_CSZ_LO +: 3]);
    dword       = avs_writedata[8:0];
    if (nbits == 4'h9) begin
      dword[8] = r.ctrl[umr_pkg::CTL_NINTH];
    end
    data_wr = avs_write && {avs_address[3:2], 2'h0} == umr_pkg::OFS_DATA;

    // A data write is held off while a frame is on the line.
    next_r.waitreq = 1'b1;
    if ((avs_read || avs_write) && r.waitreq && !(data_wr && r.busy)) begin
      next_r.waitreq = 1'b0;
      next_r.rdata   = 32'h0000_0000;
      if (avs_read) begin
        unique case ({avs_address[3:2], 2'h0})
          umr_pkg::OFS_CTRL:   next_r.rdata[9:0] = r.ctrl;
          umr_pkg::OFS_STATUS: next_r.rdata[1:0] = {r.busy, r.tx_complete_flag};
          umr_pkg::OFS_DIV:    next_r.rdata[15:0] = r.div;
          default:             next_r.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (avs_write && !r.waitreq) begin
      unique case ({avs_address[3:2], 2'h0})
        umr_pkg::OFS_CTRL: next_r.ctrl = avs_writedata[9:0];
        umr_pkg::OFS_STATUS: begin
          if (avs_writedata[umr_pkg::ST_TXC]) begin
            next_r.tx_complete_flag = 1'b0;
          end
        end
        umr_pkg::OFS_DATA: begin
          next_r.frame = build(dword, nbits, r.ctrl[umr_pkg::CTL_PEN], r.ctrl[umr_pkg::CTL_PODD]);
          next_r.last  = nbits + {3'h0, r.ctrl[umr_pkg::CTL_PEN]} + {3'h0, r.ctrl[umr_pkg::CTL_TWO_STOP]}
                         + 4'h1;
          next_r.busy  = 1'b1;
          next_r.bidx  = 4'h0;
          next_r.cnt   = 5'h01;
          next_r.txd   = 1'b0;
        end
        default: next_r.div = avs_writedata[15:0];
      endcase
    end

    // The first bit may be short by under one tick since it does not wait for a tick edge.
    if (r.busy && tick) begin
      if (r.cnt == umr_pkg::spb(r.ctrl[umr_pkg::CTL_DSPD])) begin
        next_r.cnt = 5'h01;
        if (r.bidx == r.last) begin
          next_r.busy = 1'b0;
          next_r.txd  = 1'b1;
          next_r.tx_complete_flag  = 1'b1;
        end else begin
          next_r.bidx = r.bidx + 4'h1;
          next_r.txd  = r.frame[r.bidx + 4'h1];
        end
      end else begin
        next_r.cnt = r.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r         <= '0;
      r.ctrl    <= umr_pkg::CTRL_RST;
      r.div     <= umr_pkg::DIV_RST;
      r.frame   <= 13'h1fff;
      r.txd     <= 1'b1;
      r.waitreq <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign ser.line        = r.txd;
  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.waitreq;
endmodule

// ### sim/umr_link_properties.sv
// Concurrent checks on the joined serial line and on the receiver's register port.
`timescale 1ns/1ps
module umr_link_properties (
  input wire logic        clk,             // System clock.
  input wire logic        reset,           // Synchronous reset, active high.
  input wire logic        line,            // Serial line, idle high.
  input wire logic [3:0]  avs_address,     // Receiver byte address.
  input wire logic        avs_read,        // Receiver read request.
  input wire logic        avs_write,       // Receiver write request.
  input wire logic [31:0] avs_readdata,    // Receiver read data.
  input wire logic        avs_waitrequest  // Receiver wait request.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_read_done;
    avs_read && !avs_waitrequest;
  endsequence

  chk_idle_after_reset: assert property ($fell(reset) |-> line)
    else $error("line not idle after reset");
  chk_start_min_len: assert property ($fell(line) |-> !line [*6])
    else $error("low bit shorter than allowed");
  chk_frame_bounded: assert property ($fell(line) |-> ##[1:1000] line)
    else $error("line stuck low past a frame");
  chk_answer_next: assert property (s_taken |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait request low for more than one cycle");
  chk_no_spurious: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  chk_status_width: assert property (s_read_done ##0 (avs_address[3:2] == 2'h1)
    |-> avs_readdata[31:5] == 27'h0)
    else $error("status read has stray bits");
  chk_data_width: assert property (s_read_done ##0 (avs_address[3:2] == 2'h2)
    |-> avs_readdata[31:9] == 23'h0)
    else $error("data read has stray bits");
endmodule

// ### sim/uart_rx_recovery_multiproc_filter_test.sv
// Bench joining transmitter and receiver, plus a receiver fed by a scripted line.
`timescale 1ns/1ps
module uart_rx_recovery_multiproc_filter_test;
  logic             clk;
  logic             reset;
  logic             line_b;
  logic [2:0]       rd;
  logic [2:0]       wr;
  logic [2:0][3:0]  addr;
  logic [2:0][31:0] wdata;
  logic [2:0][31:0] rdata;
  logic [2:0]       wreq;
  logic [31:0]      q;
  int               failures;
  int               checks;
  // Mode table: receiver control, transmitter control, sent value, expected data, expected status.
  localparam logic [31:0] RXC_T [11] = '{32'h01c, 32'h01e, 32'h004, 32'h03c, 32'h05c, 32'h05c, 32'h03d, 32'h03d,
                                         32'h01d, 32'h0dc, 32'h00c};
  localparam logic [31:0] TXC_T [11] = '{32'h018, 32'h01a, 32'h000, 32'h238, 32'h058, 32'h0d8, 32'h038, 32'h238,
                                         32'h118, 32'h0d8, 32'h008};
  localparam logic [31:0] DAT_T [11] = '{32'ha5, 32'h3c, 32'hff, 32'h12, 32'h07, 32'h07, 32'h44, 32'h21, 32'h66,
                                         32'h07, 32'hff};
  localparam logic [31:0] ED_T [11]  = '{32'h0a5, 32'h03c, 32'h01f, 32'h112, 32'h007, 32'h007, 32'h000, 32'h121,
                                         32'h066, 32'h007, 32'h03f};
  localparam logic [31:0] ES_T [11]  = '{32'h01, 32'h01, 32'h01, 32'h11, 32'h01, 32'h09, 32'h00, 32'h11, 32'h01,
                                         32'h01, 32'h01};

  umr_line_if link_a ();
  umr_line_if link_b ();
  assign link_b.line = line_b;

  umr_tx i_umr_tx (.clk(clk), .reset(reset), .ser(link_a.tx_end), .avs_address(addr[0]), .avs_read(rd[0]),
    .avs_write(wr[0]), .avs_writedata(wdata[0]), .avs_readdata(rdata[0]), .avs_waitrequest(wreq[0]));
  umr_rx i_umr_rx (.clk(clk), .reset(reset), .ser(link_a.rx_end), .avs_address(addr[1]), .avs_read(rd[1]),
    .avs_write(wr[1]), .avs_writedata(wdata[1]), .avs_readdata(rdata[1]), .avs_waitrequest(wreq[1]));
  umr_rx i_umr_rx_b (.clk(clk), .reset(reset), .ser(link_b.rx_end), .avs_address(addr[2]), .avs_read(rd[2]),
    .avs_write(wr[2]), .avs_writedata(wdata[2]), .avs_readdata(rdata[2]), .avs_waitrequest(wreq[2]));
  umr_link_properties i_umr_link_properties (.clk(clk), .reset(reset), .line(link_a.line), .avs_address(addr[1]),
    .avs_read(rd[1]), .avs_write(wr[1]), .avs_readdata(rdata[1]), .avs_waitrequest(wreq[1]));

  always #50 clk = ~clk;

  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    $display("wrong value wait bound expected done seen hang");
    failures++;
    final_report();
  endtask

  task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask

  // Called right after a rising edge; returns right after a later one.
  task automatic access(input int s, input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] r);
    int n;
    n = 0;
    addr[s] <= a;
    wdata[s] <= d;
    if (w) begin
      wr[s] <= 1'b1;
    end else begin
      rd[s] <= 1'b1;
    end
    @(posedge clk);
    while (wreq[s] !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 500) timeout();
    end
    r = rdata[s];
    rd[s] <= 1'b0;
    wr[s] <= 1'b0;
    @(posedge clk);
  endtask

  task automatic send_tx(input logic [31:0] d);
    int n;
    logic [31:0] s;
    n = 0;
    access(0, 1'b1, umr_pkg::OFS_DATA, d, s);
    // A write held off behind a running frame finds that frame's completion flag already set.
    access(0, 1'b1, umr_pkg::OFS_STATUS, 32'h1, s);
    s = 32'h0;
    while (s[umr_pkg::ST_TXC] !== 1'b1) begin
      access(0, 1'b0, umr_pkg::OFS_STATUS, 32'h0, s);
      n++;
      if (n > 400) timeout();
    end
    access(0, 1'b1, umr_pkg::OFS_STATUS, 32'h1, s);
  endtask

  // Scripted line, one clock per sample at divisor zero; one sample may be inverted.
  task automatic send_raw(input logic [9:0] frame, input int glitch);
    for (int i = 0; i < 176; i++) begin
      line_b <= (i < 160) ? (frame[i / 16] ^ (i == glitch)) : 1'b1;
      @(posedge clk);
    end
  endtask

  task automatic check_rx(input int s, input logic [31:0] es, input logic [31:0] ed);
    access(s, 1'b0, umr_pkg::OFS_STATUS, 32'h0, q);
    compare("rx status", es, q);
    access(s, 1'b0, umr_pkg::OFS_DATA, 32'h0, q);
    compare("rx data", ed, q);
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    line_b = 1'b1;
    rd = '0;
    wr = '0;
    addr = '0;
    wdata = '0;
    failures = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    access(1, 1'b0, umr_pkg::OFS_CTRL, 32'h0, q);
    compare("rx ctrl reset", 32'h018, q);
    access(1, 1'b0, umr_pkg::OFS_DIV, 32'h0, q);
    compare("rx divisor reset", 32'h3, q);
    access(0, 1'b0, umr_pkg::OFS_CTRL, 32'h0, q);
    compare("tx ctrl reset", 32'h018, q);
    for (int s = 0; s < 3; s++) begin
      access(s, 1'b1, umr_pkg::OFS_DIV, 32'h0, q);
    end
    $display("test reset values done");
    for (int k = 0; k < 11; k++) begin
      access(1, 1'b1, umr_pkg::OFS_CTRL, RXC_T[k], q);
      access(0, 1'b1, umr_pkg::OFS_CTRL, TXC_T[k], q);
      send_tx(DAT_T[k]);
      check_rx(1, ES_T[k], ED_T[k]);
    end
    access(1, 1'b1, umr_pkg::OFS_CTRL, 32'h03c, q);
    access(0, 1'b1, umr_pkg::OFS_CTRL, 32'h038, q);
    send_tx(32'h33);
    check_rx(1, 32'h01, 32'h033);
    $display("test frame modes done");
    access(1, 1'b1, umr_pkg::OFS_CTRL, 32'h01c, q);
    access(0, 1'b1, umr_pkg::OFS_CTRL, 32'h018, q);
    access(0, 1'b1, umr_pkg::OFS_DATA, 32'h11, q);
    send_tx(32'h22);
    check_rx(1, 32'h01, 32'h011);
    check_rx(1, 32'h01, 32'h022);
    access(1, 1'b0, umr_pkg::OFS_STATUS, 32'h0, q);
    compare("rx status empty", 32'h00, q);
    $display("test back to back done");
    access(2, 1'b1, umr_pkg::OFS_CTRL, 32'h01c, q);
    send_raw(10'h0b4, -1);
    check_rx(2, 32'h03, 32'h05a);
    send_raw(10'h2b4, 24);
    check_rx(2, 32'h01, 32'h05a);
    repeat (3) send_raw(10'h2b4, -1);
    check_rx(2, 32'h01, 32'h05a);
    check_rx(2, 32'h01, 32'h05a);
    send_raw(10'h2b4, -1);
    check_rx(2, 32'h05, 32'h05a);
    send_raw(10'h3ff, 0);
    access(2, 1'b0, umr_pkg::OFS_STATUS, 32'h0, q);
    compare("noise status", 32'h00, q);
    $display("test scripted line done");
    final_report();
  end
endmodule
